// >>> design/mip_pkg.sv
// Package of the masked I/O port: register offsets, reset values,
// identification words and the structs that carry pad and trigger settings.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
package mip_pkg;

    localparam int NPINS = 8;
    localparam int ADDR_W = 12;

    // Byte offsets of the register map
    localparam logic [11:0] OFF_DIRECTION = 12'h400;
    localparam logic [11:0] OFF_SENSE = 12'h404;
    localparam logic [11:0] OFF_BOTH = 12'h408;
    localparam logic [11:0] OFF_POLARITY = 12'h40C;
    localparam logic [11:0] OFF_MASK = 12'h410;
    localparam logic [11:0] OFF_RAW = 12'h414;
    localparam logic [11:0] OFF_MASKED = 12'h418;
    localparam logic [11:0] OFF_CLEAR = 12'h41C;
    localparam logic [11:0] OFF_ALT = 12'h420;
    localparam logic [11:0] OFF_DRV_LOW = 12'h500;
    localparam logic [11:0] OFF_DRV_MID = 12'h504;
    localparam logic [11:0] OFF_DRV_HIGH = 12'h508;
    localparam logic [11:0] OFF_OPEN_DRAIN = 12'h50C;
    localparam logic [11:0] OFF_PULL_UP = 12'h510;
    localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
    localparam logic [11:0] OFF_SLEW = 12'h518;
    localparam logic [11:0] OFF_DIG_EN = 12'h51C;
    localparam logic [11:0] OFF_LOCK = 12'h520;
    localparam logic [11:0] OFF_COMMIT = 12'h524;
    localparam logic [11:0] OFF_PERIPH_ID = 12'hFD0;
    localparam logic [11:0] OFF_CELL_ID = 12'hFF0;

    // Data window: address bits 11:10 zero, bits 9:2 are the pin mask
    localparam int MASK_LSB = 2;
    localparam int MASK_MSB = 9;
    localparam logic [1:0] DATA_WIN_TAG = 2'h0;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DRV_LOW = 8'hFF;
    localparam logic [7:0] RST_COMMIT_ALL = 8'hFF;
    localparam logic [31:0] LOCK_READ_LOCKED = 32'h00000001;
    localparam logic [31:0] LOCK_READ_OPEN = 32'h00000000;

    // Unlock key, arbitrary value
    localparam logic [31:0] UNLOCK_KEY = 32'h00005A5A;

    // Identification bytes, arbitrary values, word n in byte n
    localparam logic [63:0] PERIPH_ID_BYTES = 64'h0807060504030201;
    localparam logic [31:0] CELL_ID_BYTES = 32'h44332211;

    typedef struct packed {
        logic [7:0] drive_low;
        logic [7:0] drive_mid;
        logic [7:0] drive_high;
        logic [7:0] open_drain;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] slew_limit;
        logic [7:0] digital_en;
    } mip_pad_cfg_s;

    typedef struct packed {
        logic sense;
        logic both_edges;
        logic polarity;
    } mip_trig_cfg_s;

endpackage

// >>> design/mip_pin_detect.sv
// One pin's synchroniser and interrupt condition detector.
// Assumes the pin is asynchronous and the clear is a one-cycle pulse.
`timescale 1ns/1ps
module mip_pin_detect
    import mip_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Pin and settings
    input wire logic pin_raw,
    input wire mip_trig_cfg_s cfg,
    input wire logic clear,
    // Results
    output logic pin_sync,
    output logic raw_status
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic latch_reg;
    logic latch_next;
    wire rise = sync_reg & ~prev_reg;
    wire fall = ~sync_reg & prev_reg;
    // (R21) edge polarity choice
    wire edge_hit = ~cfg.sense &
        ((rise & (cfg.both_edges | cfg.polarity)) |
         (fall & (cfg.both_edges | ~cfg.polarity)));
    // (R21) level polarity choice
    wire level_hit = cfg.sense & (sync_reg == cfg.polarity);

    // (R6) latch until cleared, set wins
    assign latch_next = edge_hit | (latch_reg & ~clear);
    // (R23) level follows the pin
    assign raw_status = cfg.sense ? level_hit : latch_reg;
    assign pin_sync = sync_reg;

    // (R22) two-stage sync then compare
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
            latch_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            latch_reg <= latch_next;
        end
    end
endmodule

// >>> design/mip_port_top.sv
// Eight-pin masked I/O port with interrupt detection, lock/commit guard
// over the debug pins' alternate-function bits, pad configuration and identification.
// Assumes an Avalon-MM master with byte addresses and one clock.
//
// What this block does and relies on
// (R1) Address bits 9:2 mask data accesses
// (R2) Data register spans 256 word locations
// (R3) Masked write changes only selected bits
// (R4) Masked read returns zero for unselected bits
// (R5) All pin conditions form one interrupt
// (R6) Edge interrupt stays latched until cleared
// (R7) Level source holds level until recognised
// (R8) Sense, both-edges, event bits choose trigger
// (R9) Per-pin mask gates interrupt output
// (R10) Raw status ignores mask
// (R11) Masked status drives the interrupt output
// (R12) Writing one clears latched interrupt
// (R13) Unmasked trigger pin pulses converter trigger
// (R14) Software masks before changing trigger bits
// (R15) Alternate function hands pin to peripheral
// (R16) Protected alternate bits need unlock and commit
// (R17) Pad bits go out as static configuration
// (R18) Read-only identification words fixed at reset
// (R19) Direction zero captures input, one drives
// (R20) Reset: pins undriven, debug pins alternate
// (R21) Trigger encoding of sense, both, event
// (R22) Inputs synchronised, edges by sample comparison
// (R23) Level raw status follows the pin
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module mip_port_top
    import mip_pkg::*;
#(
    parameter logic [7:0] DEBUG_PINS = 8'h00,
    parameter logic TRIG_ENABLE = 1'b1,
    parameter int TRIG_PIN = 4
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // Alternate-function peripherals
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    output logic [7:0] alt_in,
    // Pad configuration
    output mip_pad_cfg_s pad_cfg,
    // Interrupt and converter trigger
    output logic port_irq,
    output logic converter_trigger
);
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [7:0] pin_value_reg;
    logic [7:0] pin_value_next;
    logic [7:0] pin_direction_reg;
    logic [7:0] irq_sense_reg;
    logic [7:0] irq_both_edges_reg;
    logic [7:0] irq_polarity_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] alt_function_select_reg;
    logic [7:0] alt_function_select_next;
    logic [7:0] commit_enable_reg;
    logic unlocked_reg;
    mip_pad_cfg_s pad_reg;
    logic trig_prev_reg;
    logic trig_pulse_reg;
    logic [7:0] pin_sync;
    logic [7:0] irq_raw_status_reg;
    logic [7:0] irq_masked_status_reg;

    // Bus handshake: one wait cycle, then the answer
    wire req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    wire wr_go = avs_write & ack_reg & avs_byteenable[0];
    wire [7:0] wb = avs_writedata[7:0];
    wire [11:0] a = avs_address;

    // (R2) data window decode
    wire data_hit = (a[11:10] == DATA_WIN_TAG);
    // (R1) address bits as pin mask
    wire [7:0] addr_mask = a[MASK_MSB:MASK_LSB];

    wire wr_dir = wr_go & (a == OFF_DIRECTION);
    wire wr_sense = wr_go & (a == OFF_SENSE);
    wire wr_both = wr_go & (a == OFF_BOTH);
    wire wr_pol = wr_go & (a == OFF_POLARITY);
    wire wr_mask = wr_go & (a == OFF_MASK);
    wire wr_clear = wr_go & (a == OFF_CLEAR);
    wire wr_alt = wr_go & (a == OFF_ALT);
    wire wr_dlow = wr_go & (a == OFF_DRV_LOW);
    wire wr_dmid = wr_go & (a == OFF_DRV_MID);
    wire wr_dhigh = wr_go & (a == OFF_DRV_HIGH);
    wire wr_od = wr_go & (a == OFF_OPEN_DRAIN);
    wire wr_pu = wr_go & (a == OFF_PULL_UP);
    wire wr_pd = wr_go & (a == OFF_PULL_DOWN);
    wire wr_slew = wr_go & (a == OFF_SLEW);
    wire wr_den = wr_go & (a == OFF_DIG_EN);
    wire wr_lock = avs_write & ack_reg & (a == OFF_LOCK);
    wire wr_commit = wr_go & (a == OFF_COMMIT);
    wire wr_data = wr_go & data_hit;
    wire [7:0] icr_bits = wr_clear ? wb : RST_ZERO;

    // (R19) input bits capture the pin, output bits hold stored data
    wire [7:0] captured = pin_sync & pad_reg.digital_en;
    // (R3) masked write keeps unselected bits
    wire [7:0] written = wr_data ?
        ((wb & addr_mask) | (pin_value_reg & ~addr_mask)) : pin_value_reg;
    assign pin_value_next = (written & pin_direction_reg) |
        (captured & ~pin_direction_reg);

    // (R16) protected bits change only when unlocked and committed
    wire [7:0] alt_allow = ~DEBUG_PINS |
        (commit_enable_reg & {8{unlocked_reg}});
    assign alt_function_select_next = wr_alt ?
        ((wb & alt_allow) | (alt_function_select_reg & ~alt_allow)) :
        alt_function_select_reg;

    // (R8) per-pin trigger detection
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++)
        begin : g_pin
            mip_trig_cfg_s tcfg;
            assign tcfg = '{sense: irq_sense_reg[gi],
                            both_edges: irq_both_edges_reg[gi],
                            polarity: irq_polarity_reg[gi]};
            mip_pin_detect u_det (
                .ref_clk(ref_clk),
                .srst(srst),
                .pin_raw(pin_in[gi]),
                .cfg(tcfg),
                // (R12) clear by writing one
                .clear(icr_bits[gi]),
                .pin_sync(pin_sync[gi]),
                // (R10) raw status unmasked
                .raw_status(irq_raw_status_reg[gi])
            );
        end
    endgenerate

    // (R9) mask gates each pin
    assign irq_masked_status_reg = irq_raw_status_reg & irq_mask_reg;
    // (R11) any masked bit raises output
    // (R5) single port interrupt
    assign port_irq = |irq_masked_status_reg;

    // (R15) peripheral or data register owns the pin
    assign pin_out = alt_function_select_reg & alt_out |
        ~alt_function_select_reg & pin_value_reg;
    assign pin_oe = alt_function_select_reg & alt_oe |
        ~alt_function_select_reg & pin_direction_reg;
    assign alt_in = pin_sync & pad_reg.digital_en;
    // (R17) static pad configuration
    assign pad_cfg = pad_reg;

    // (R13) trigger pulse on unmasked trigger pin condition
    wire trig_level = TRIG_ENABLE & irq_masked_status_reg[TRIG_PIN];
    assign converter_trigger = trig_pulse_reg;

    // Peripheral words straddle two 32-byte blocks: rebase the index
    wire [2:0] id_idx = a[4:2] ^ 3'h4;
    wire periph_id_hit = (a >= OFF_PERIPH_ID) && (a < OFF_CELL_ID);
    wire cell_id_hit = (a[11:4] == OFF_CELL_ID[11:4]);

    // Read selection
    always_comb
    begin
        readdata_next = 32'h00000000;
        if (data_hit)
            // (R4) unselected bits read zero
            readdata_next[7:0] = pin_value_reg & addr_mask;
        else if (periph_id_hit)
            // (R18) fixed identification words
            readdata_next[7:0] = PERIPH_ID_BYTES[id_idx*8 +: 8];
        else if (cell_id_hit)
            readdata_next[7:0] = CELL_ID_BYTES[id_idx[1:0]*8 +: 8];
        else
        begin
            unique case (a)
                OFF_DIRECTION: readdata_next[7:0] = pin_direction_reg;
                OFF_SENSE: readdata_next[7:0] = irq_sense_reg;
                OFF_BOTH: readdata_next[7:0] = irq_both_edges_reg;
                OFF_POLARITY: readdata_next[7:0] = irq_polarity_reg;
                OFF_MASK: readdata_next[7:0] = irq_mask_reg;
                OFF_RAW: readdata_next[7:0] = irq_raw_status_reg;
                OFF_MASKED: readdata_next[7:0] = irq_masked_status_reg;
                OFF_ALT: readdata_next[7:0] = alt_function_select_reg;
                OFF_DRV_LOW: readdata_next[7:0] = pad_reg.drive_low;
                OFF_DRV_MID: readdata_next[7:0] = pad_reg.drive_mid;
                OFF_DRV_HIGH: readdata_next[7:0] = pad_reg.drive_high;
                OFF_OPEN_DRAIN: readdata_next[7:0] = pad_reg.open_drain;
                OFF_PULL_UP: readdata_next[7:0] = pad_reg.pull_up;
                OFF_PULL_DOWN: readdata_next[7:0] = pad_reg.pull_down;
                OFF_SLEW: readdata_next[7:0] = pad_reg.slew_limit;
                OFF_DIG_EN: readdata_next[7:0] = pad_reg.digital_en;
                OFF_LOCK: readdata_next = unlocked_reg ?
                    LOCK_READ_OPEN : LOCK_READ_LOCKED;
                OFF_COMMIT: readdata_next[7:0] = commit_enable_reg;
                default: readdata_next = 32'h00000000;
            endcase
        end
    end
    assign avs_readdata = readdata_reg;

    // Bus answer and trigger flops
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
            trig_prev_reg <= 1'b0;
            trig_pulse_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req & ~ack_reg;
            if (avs_read & ~ack_reg)
                readdata_reg <= readdata_next;
            trig_prev_reg <= trig_level;
            trig_pulse_reg <= trig_level & ~trig_prev_reg;
        end
    end

    // Data, direction and interrupt settings
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pin_value_reg <= RST_ZERO;
            pin_direction_reg <= RST_ZERO;
            irq_sense_reg <= RST_ZERO;
            irq_both_edges_reg <= RST_ZERO;
            irq_polarity_reg <= RST_ZERO;
            irq_mask_reg <= RST_ZERO;
        end
        else
        begin
            pin_value_reg <= pin_value_next;
            if (wr_dir)
                pin_direction_reg <= wb;
            if (wr_sense)
                irq_sense_reg <= wb;
            if (wr_both)
                irq_both_edges_reg <= wb;
            if (wr_pol)
                irq_polarity_reg <= wb;
            if (wr_mask)
                irq_mask_reg <= wb;
        end
    end

    // Lock, commit and alternate-function select
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            unlocked_reg <= 1'b0;
            commit_enable_reg <= RST_COMMIT_ALL & ~DEBUG_PINS;
            // (R20) debug pins default to alternate function
            alt_function_select_reg <= DEBUG_PINS;
        end
        else
        begin
            if (wr_lock)
                unlocked_reg <= (avs_writedata == UNLOCK_KEY);
            // (R16) commit bits writable only while unlocked
            if (wr_commit & unlocked_reg)
                commit_enable_reg <= (wb & DEBUG_PINS) |
                    (commit_enable_reg & ~DEBUG_PINS);
            alt_function_select_reg <= alt_function_select_next;
        end
    end

    // Pad configuration registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pad_reg.drive_low <= RST_DRV_LOW;
            pad_reg.drive_mid <= RST_ZERO;
            pad_reg.drive_high <= RST_ZERO;
            pad_reg.open_drain <= RST_ZERO;
            // (R20) ordinary pins undriven, debug pins pulled up
            pad_reg.pull_up <= DEBUG_PINS;
            pad_reg.pull_down <= RST_ZERO;
            pad_reg.slew_limit <= RST_ZERO;
            pad_reg.digital_en <= DEBUG_PINS;
        end
        else
        begin
            if (wr_dlow)
                pad_reg.drive_low <= wb;
            if (wr_dmid)
                pad_reg.drive_mid <= wb;
            if (wr_dhigh)
                pad_reg.drive_high <= wb;
            if (wr_od)
                pad_reg.open_drain <= wb;
            if (wr_pu)
                pad_reg.pull_up <= wb;
            if (wr_pd)
                pad_reg.pull_down <= wb;
            if (wr_slew)
                pad_reg.slew_limit <= wb;
            if (wr_den)
                pad_reg.digital_en <= wb;
        end
    end
endmodule

// >>> verification/mip_pin_partner.sv
// Partner model: the pins outside the port and the peripherals behind it.
// Assumes the bench sets the external levels and peripheral enables.
`timescale 1ns/1ps
module mip_pin_partner
(
    // Clock
    input wire logic ref_clk,
    // Port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_in,
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe,
    // Bench side
    input wire logic [7:0] ext_level,
    input wire logic [7:0] alt_en
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    logic [7:0] alt_q = 8'h5A;
    assign alt_oe = alt_en;
    assign alt_out = alt_q;
    // Peripheral data changes every cycle
    always @(posedge ref_clk)
        alt_q <= alt_q + 8'h1D;
endmodule

// >>> verification/mip_port_assertions.sv
// Concurrent checks on the masked I/O port's top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mip_port_assertions
    import mip_pkg::*;
#(
    parameter logic [7:0] DEBUG_PINS = 8'h00,
    parameter logic TRIG_ENABLE = 1'b1,
    parameter int TRIG_PIN = 4
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and peripherals
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic [7:0] alt_in,
    // Pad, interrupt, trigger
    input wire mip_pad_cfg_s pad_cfg,
    input wire logic port_irq,
    input wire logic converter_trigger
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [7:0] pin_q;
    logic [4:0] pin_chg;
    wire rd_ack = avs_read && !avs_waitrequest;
    wire wr_ack = avs_write && !avs_waitrequest;
    wire [2:0] pid_idx = avs_address[4:2] ^ 3'h4;
    wire is_id = avs_address >= OFF_PERIPH_ID && avs_address[1:0] == 2'h0;
    wire [7:0] id_exp = (avs_address >= OFF_CELL_ID) ?
        CELL_ID_BYTES[8*avs_address[3:2] +: 8] :
        PERIPH_ID_BYTES[8*pid_idx +: 8];

    // Recent pin changes, a legal cause of interrupt changes
    always_ff @(posedge ref_clk)
    begin
        pin_q <= pin_in;
        pin_chg <= {pin_chg[3:0], pin_q != pin_in};
    end

    wait_one_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("request not answered in one wait");
    data_mask_a:
    assert property (rd_ack && avs_address[11:10] == 2'h0 |->
        (avs_readdata & ~{24'h0, avs_address[9:2]}) == 32'h0)
        else $error("unselected data bit read nonzero");
    id_word_a:
    assert property (rd_ack && is_id |-> avs_readdata == {24'h0, id_exp})
        else $error("identification word wrong");
    reset_quiet_a:
    assert property ($past(srst) |-> pin_oe == (DEBUG_PINS & alt_oe) &&
        pin_out == (DEBUG_PINS & alt_out) && !port_irq &&
        pad_cfg == {RST_DRV_LOW, 24'h0, DEBUG_PINS, 16'h0, DEBUG_PINS})
        else $error("outputs not at reset values");
    pad_static_a:
    assert property (!$stable(pad_cfg) |-> $past(wr_ack))
        else $error("pad configuration moved without a write");
    oe_cause_a:
    assert property (!$stable(pin_oe) |-> $past(wr_ack) || !$stable(alt_oe))
        else $error("pin enable moved without cause");
    out_cause_a:
    assert property (!$stable(pin_out) |->
        $past(wr_ack) || !$stable(alt_out) || (|pin_chg))
        else $error("pin output moved without cause");
    irq_cause_a:
    assert property ($changed(port_irq) |-> $past(wr_ack) || (|pin_chg))
        else $error("interrupt moved without cause");
    trig_pulse_a:
    assert property (converter_trigger |=> !converter_trigger)
        else $error("converter trigger longer than one cycle");
    trig_cause_a:
    assert property (converter_trigger |-> $past(port_irq))
        else $error("converter trigger without interrupt");
endmodule

bind mip_port_top mip_port_assertions #(
    .DEBUG_PINS(DEBUG_PINS), .TRIG_ENABLE(TRIG_ENABLE), .TRIG_PIN(TRIG_PIN)
) u_mip_chk (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .pad_cfg(pad_cfg), .port_irq(port_irq),
    .converter_trigger(converter_trigger)
);

// >>> verification/mip_port_top_tb.sv
// Self-checking bench of the masked I/O port with a reference model.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/1ps
module mip_port_top_tb
    import mip_pkg::*;
;
    localparam logic [7:0] DBG = 8'h81;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rdat;
    logic avs_waitrequest, port_irq, converter_trigger, unl;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
    logic [7:0] ext_level = 8'h00;
    logic [7:0] alt_en = 8'h00;
    logic [7:0] d, alt, cmt, m, l0, l1, ex, wm;
    logic [31:0] rnd = 32'hBE3F2BAC;
    logic [95:0] ids = {CELL_ID_BYTES, PERIPH_ID_BYTES};
    logic [11:0] ta[8] = '{OFF_ALT, OFF_COMMIT, OFF_LOCK, OFF_COMMIT,
        OFF_ALT, OFF_LOCK, OFF_ALT, OFF_COMMIT};
    logic [31:0] tw[8] = '{32'h0, 32'hFF, UNLOCK_KEY, 32'hFF, 32'h0, 32'h0,
        32'hFF, 32'h0};
    logic [2:0] modes[5] = '{3'b001, 3'b000, 3'b010, 3'b101, 3'b100};
    mip_pad_cfg_s pad_cfg;
    int error_cnt = 0;
    int checked = 0;
    int trig_cnt = 0;
    int t0;

    mip_port_top #(.DEBUG_PINS(DBG)) DUT (
        .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .pad_cfg(pad_cfg), .port_irq(port_irq),
        .converter_trigger(converter_trigger));
    mip_pin_partner u_partner (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .alt_out(alt_out),
        .alt_oe(alt_oe), .ext_level(ext_level), .alt_en(alt_en));

    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk)
        if (converter_trigger === 1'b1)
            trig_cnt++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e,
        input logic [63:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            end_of_test();
        end
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [63:0] e,
        input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, {32'h0, rdat});
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        chk("pad_cfg", {RST_DRV_LOW, 24'h0, DBG, 16'h0, DBG}, pad_cfg);
        rchk(OFF_ALT, DBG, "alt_sel");
        rchk(OFF_DIRECTION, 8'h00, "direction");
        for (int i = 0; i < 12; i++)
            rchk(OFF_PERIPH_ID + 12'(4 * i), ids[8*i +: 8], "ident");
        $display("done reset and ident");
        alt = DBG;
        cmt = ~DBG;
        unl = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, ta[i], tw[i]);
            wm = ~DBG | (unl ? (cmt & DBG) : 8'h00);
            if (ta[i] == OFF_ALT)
                alt = (alt & ~wm) | (tw[i][7:0] & wm);
            if (ta[i] == OFF_COMMIT && unl)
                cmt = (cmt & ~DBG) | (tw[i][7:0] & DBG);
            if (ta[i] == OFF_LOCK)
                unl = (tw[i] == UNLOCK_KEY);
            rchk(OFF_ALT, alt, "alt_sel");
            rchk(OFF_COMMIT, cmt, "commit");
            rchk(OFF_LOCK, {31'h0, !unl}, "lock");
        end
        alt_en <= 8'hC3;
        @(negedge ref_clk);
        chk("pin_oe", 8'hC3 & alt, pin_oe);
        chk("alt_out", alt_out & alt, pin_out & alt);
        xfer(1'b1, OFF_ALT, 32'h0);
        $display("done lock and alternate");
        xfer(1'b1, OFF_DIRECTION, 32'hFF);
        d = rnd[7:0];
        xfer(1'b1, 12'h3FC, {24'h0, d});
        for (int i = 0; i < 24; i++)
        begin
            rnd = lfsr(rnd);
            m = rnd[9:2];
            avs_byteenable <= (i == 5) ? 4'hE : 4'hF;
            xfer(1'b1, {2'h0, m, 2'h0}, {24'h0, rnd[31:24]});
            if (i != 5)
                d = (d & ~m) | (rnd[31:24] & m);
            @(negedge ref_clk);
            chk("pin_out", d, pin_out);
            rchk({2'h0, rnd[19:12], 2'h0}, d & rnd[19:12], "data");
        end
        xfer(1'b1, 12'h600, 32'hFF);
        rchk(12'h600, 32'h0, "unmapped");
        $display("done masked data");
        xfer(1'b1, OFF_DIRECTION, 32'h0);
        xfer(1'b1, OFF_DIG_EN, 32'hFF);
        @(negedge ref_clk);
        chk("dig_en", 8'hFF, pad_cfg.digital_en);
        ext_level <= rnd[7:0];
        repeat (6) @(posedge ref_clk);
        rchk(12'h3FC, rnd[7:0], "input");
        chk("alt_in", rnd[7:0], alt_in);
        $display("done input capture");
        for (int k = 0; k < 5; k++)
        begin
            rnd = lfsr(rnd);
            xfer(1'b1, OFF_MASK, 32'h0);
            xfer(1'b1, OFF_SENSE, {24'h0, {8{modes[k][2]}}});
            xfer(1'b1, OFF_BOTH, {24'h0, {8{modes[k][1]}}});
            xfer(1'b1, OFF_POLARITY, {24'h0, {8{modes[k][0]}}});
            l0 = modes[k][2] ? {8{~modes[k][0]}} : rnd[7:0];
            l1 = rnd[15:8];
            m = rnd[23:16] | 8'h10;
            ext_level <= l0;
            repeat (6) @(posedge ref_clk);
            xfer(1'b1, OFF_CLEAR, 32'hFF);
            xfer(1'b1, OFF_MASK, {24'h0, m});
            t0 = trig_cnt;
            ext_level <= l1;
            repeat (6) @(posedge ref_clk);
            if (modes[k][2])
                ex = modes[k][0] ? l1 : ~l1;
            else if (modes[k][1])
                ex = l0 ^ l1;
            else
                ex = modes[k][0] ? (~l0 & l1) : (l0 & ~l1);
            rchk(OFF_RAW, ex, "raw");
            rchk(OFF_MASKED, ex & m, "masked");
            chk("port_irq", |(ex & m), port_irq);
            chk("trigger", ex[4], trig_cnt - t0);
            xfer(1'b1, OFF_CLEAR, {24'h0, rnd[31:24]});
            ex = modes[k][2] ? ex : (ex & ~rnd[31:24]);
            rchk(OFF_RAW, ex, "raw_after_clear");
        end
        $display("done interrupts");
        end_of_test();
    end
endmodule
